/* File: core/synth_cfg_pkg.sv */
package synth_cfg_pkg;
  // Control codes in the three lowest bits of each serial word
  localparam logic [2:0] CTL_FRACTIONAL_VALUE = 3'h0;
  localparam logic [2:0] CTL_REFDIV = 3'h2;
  localparam logic [2:0] CTL_FUNC = 3'h3;
  localparam int CTL_HI = 2;

  // Reference divider word fields
  localparam int SLIP_BIT = 28;
  localparam int CP_HI = 27;
  localparam int CP_LO = 24;
  localparam int PRESC_BIT = 22;
  localparam int HALF_BIT = 21;
  localparam int DBL_BIT = 20;
  localparam int RCNT_HI = 19;
  localparam int RCNT_LO = 15;
  localparam int STEP_HI = 14;
  localparam int STEP_LO = 3;

  // Function word fields
  localparam int BLEED_HI = 24;
  localparam int BLEED_LO = 22;
  localparam int BLEED_EN_BIT = 21;
  localparam int LOCK_LOSS_BIT = 16;
  localparam int NSEL_BIT = 15;
  localparam int MODRST_BIT = 14;
  localparam int RAMP_HI = 11;
  localparam int RAMP_LO = 10;
  localparam int PSK_BIT = 9;
  localparam int FSK_BIT = 8;
  localparam int LOCK_PREC_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PD_BIT = 5;

  // Reset values: R counter code 1, function word with its fixed one bit
  localparam logic [31:0] REFDIV_RST = 32'h0000_8002;
  localparam logic [31:0] FUNC_RST = 32'h0002_0003;
  localparam logic [31:0] FRACTIONAL_VALUE_RST = 32'h0000_0000;

  // AHB byte addresses
  localparam logic [7:0] ADDR_WORD = 8'h00;
  localparam logic [7:0] ADDR_REFDIV = 8'h04;
  localparam logic [7:0] ADDR_FUNC = 8'h08;
  localparam logic [7:0] ADDR_FRACTIONAL_VALUE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Timing, in picoseconds, and derived cycle counts
  localparam int CLK_PERIOD_PS = 20000;
  localparam int LOCK_COARSE_PS = 14000;
  localparam int LOCK_FINE_PS = 6000;
  localparam int UNLOCK_PS = 22000;
  localparam int INT_PIPE_CYCLES = 4;
  localparam int LOCK_COUNT = 5;
  localparam logic [4:0] MEASURE_LAST = 5'h1f;

  // Longest time rounded down to whole cycles, never below one
  function automatic int cyc_floor(input int t_ps);
    int c;
    c = t_ps / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [3:0] LOCK_COARSE_CYC = 4'(cyc_floor(LOCK_COARSE_PS));
  localparam logic [3:0] LOCK_FINE_CYC = 4'(cyc_floor(LOCK_FINE_PS));
  localparam logic [3:0] UNLOCK_CYC = 4'(cyc_floor(UNLOCK_PS));
endpackage

/* File: core/serial_word_rx.sv */
// Serial receiver: pins synchronised, shift on clock rise, commit on latch rise
module serial_word_rx (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  output logic word_valid,
  output logic [31:0] word
);
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;
  logic [1:0] prev_ff;
  logic [31:0] shift_ff;
  logic valid_ff;
  logic [31:0] word_ff;
  wire clk_rise = sync_ff[0] & ~prev_ff[0];
  wire latch_rise = sync_ff[2] & ~prev_ff[1];

  // Two flops on every pin before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
      prev_ff <= 2'h0;
    end else begin
      meta_ff <= {ser_latch, ser_data, ser_clk};
      sync_ff <= meta_ff;
      prev_ff <= {sync_ff[2], sync_ff[0]};
    end
  end

  // Shift MSB first, present the word for one cycle on latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_ff <= 32'h0;
      valid_ff <= 1'b0;
      word_ff <= 32'h0;
    end else begin
      if (clk_rise) shift_ff <= {shift_ff[30:0], sync_ff[1]};
      valid_ff <= latch_rise;
      if (latch_rise) word_ff <= shift_ff;
    end
  end

  assign word_valid = valid_ff;
  assign word = word_ff;
endmodule

/* File: core/synth_ref_func_cfg.sv */
// Function
// - Word with control bits 010 updates only the reference divider register.
// - Word with control bits 011 updates only the function register.
// - Charge pump current code comes from bits 27..24.
// - Bit 21 inserts a divide-by-two toggle after the reference counter.
// - Doubler off: falling edge only; on: both reference edges active.
// - Reference divided by 5-bit counter, ratios 1 to 32.
// - Bits 14..3 set ramp time step length.
// - Bleed current code comes from function bits 24..22.
// - Bleed current enabled only while function bit 21 is one.
// - Lock-loss mode zero also reports a missing reference.
// - Bit 15 delays integer load to coincide with fraction load.
// - Bit 14 zero resets modulator on each frequency word write.
// - Ramp mode field bits 11..10 selects waveform.
// - Bit 9 enables phase shift keying.
// - Bit 8 enables frequency shift keying.
// - Lock detector measures OR of up and down, every 32nd pulse.
// - Lock after five short measured pulses; precision bit picks threshold.
// - Lock held until long pulse, frequency word write, power-down or, in lock-loss mode zero, a missing reference.
// - Function bit 6 is detector polarity, one is positive.
// - Bit 5 powers down; registers are retained.
// - Power-down loads counters, tristates pump, resets lock; serial stays live.
// - Control bits 000 update the frequency/fraction register.
module synth_ref_func_cfg #(
  parameter int REF_LOSS_CYC = 8192
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_latch,
  input wire logic reference_input,
  input wire logic pfd_up,
  input wire logic pfd_dn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pfd_ref_clk,
  output logic ramp_step_tick,
  output logic cycle_slip_reduce_en,
  output logic [3:0] cp_current_code,
  output logic prescaler_89,
  output logic [2:0] bleed_code,
  output logic bleed_en,
  output logic cp_tristate,
  output logic [1:0] ramp_mode,
  output logic psk_en,
  output logic fsk_en,
  output logic pd_polarity_pos,
  output logic power_down,
  output logic lock_detect,
  output logic mod_reset,
  output logic int_load,
  output logic fractional_value_load
);
  logic [31:0] refdiv_ff;
  logic [31:0] func_ff;
  logic [31:0] fractional_value_ff;
  logic ser_valid;
  logic [31:0] ser_word;

  serial_word_rx u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_latch(ser_latch),
    .word_valid(ser_valid),
    .word(ser_word)
  );

  // Status flops, declared early as the bus reads them back
  logic ref_lost_ff;
  logic pwr_dn_ff;
  logic lock_ff;

  // AHB slave: zero wait, writes to the word port go through a pending slot
  logic ap_wr_ff;
  logic pend_ff;
  logic [31:0] pend_word_ff;
  logic [31:0] rdata_ff;
  wire ap_take = hsel & htrans[1] & hready;
  wire [7:0] ap_addr = haddr[7:0];
  wire ap_word = ap_take & hwrite & (ap_addr == synth_cfg_pkg::ADDR_WORD);
  wire [31:0] status_w = {29'h0, ref_lost_ff, pwr_dn_ff, lock_ff};
  wire [31:0] rd_mux = (ap_addr == synth_cfg_pkg::ADDR_REFDIV) ? refdiv_ff :
                       (ap_addr == synth_cfg_pkg::ADDR_FUNC) ? func_ff :
                       (ap_addr == synth_cfg_pkg::ADDR_FRACTIONAL_VALUE) ? fractional_value_ff :
                       (ap_addr == synth_cfg_pkg::ADDR_STATUS) ? status_w : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_wr_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ap_wr_ff <= ap_word;
      if (ap_take && !hwrite) rdata_ff <= rd_mux;
    end
  end

  // Serial word wins a tie; the bus word waits one cycle in the slot
  wire bus_commit = pend_ff & ~ser_valid;
  wire commit = ser_valid | bus_commit;
  wire [31:0] cword = ser_valid ? ser_word : pend_word_ff;
  wire [2:0] ctl = cword[synth_cfg_pkg::CTL_HI:0];
  wire wr_refdiv = commit & (ctl == synth_cfg_pkg::CTL_REFDIV);
  wire wr_func = commit & (ctl == synth_cfg_pkg::CTL_FUNC);
  wire wr_fractional_value = commit & (ctl == synth_cfg_pkg::CTL_FRACTIONAL_VALUE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_ff <= 1'b0;
      pend_word_ff <= 32'h0;
    end else begin
      if (ap_wr_ff) pend_word_ff <= hwdata;
      pend_ff <= ap_wr_ff | (pend_ff & ser_valid);
    end
  end

  // Register commit by control bits; serial input stays live in power-down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refdiv_ff <= synth_cfg_pkg::REFDIV_RST;
      func_ff <= synth_cfg_pkg::FUNC_RST;
      fractional_value_ff <= synth_cfg_pkg::FRACTIONAL_VALUE_RST;
    end else begin
      if (wr_refdiv) refdiv_ff <= cword;
      if (wr_func) func_ff <= cword;
      if (wr_fractional_value) fractional_value_ff <= cword;
    end
  end

  // Field decode
  wire pd_cfg = func_ff[synth_cfg_pkg::PD_BIT];
  wire dbl_en = refdiv_ff[synth_cfg_pkg::DBL_BIT];
  wire half_en = refdiv_ff[synth_cfg_pkg::HALF_BIT];
  wire [4:0] r_code = refdiv_ff[synth_cfg_pkg::RCNT_HI:synth_cfg_pkg::RCNT_LO];
  wire [11:0] step_div = refdiv_ff[synth_cfg_pkg::STEP_HI:synth_cfg_pkg::STEP_LO];
  wire lock_precision_sel = func_ff[synth_cfg_pkg::LOCK_PREC_BIT];
  wire lock_loss_mode = func_ff[synth_cfg_pkg::LOCK_LOSS_BIT];
  wire nsel = func_ff[synth_cfg_pkg::NSEL_BIT];
  wire modrst_off = func_ff[synth_cfg_pkg::MODRST_BIT];

  // Reference pin and detector pulses: two-flop synchronisers
  logic [2:0] in_meta_ff;
  logic [2:0] in_sync_ff;
  logic ref_d_ff;
  logic pulse_d_ff;
  wire pfd_pulse = in_sync_ff[1] | in_sync_ff[2];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_meta_ff <= 3'h0;
      in_sync_ff <= 3'h0;
      ref_d_ff <= 1'b0;
      pulse_d_ff <= 1'b0;
    end else begin
      in_meta_ff <= {pfd_dn, pfd_up, reference_input};
      in_sync_ff <= in_meta_ff;
      ref_d_ff <= in_sync_ff[0];
      pulse_d_ff <= pfd_pulse;
    end
  end

  // Falling edge only, or both edges when doubled
  wire ref_fall = ~in_sync_ff[0] & ref_d_ff;
  wire ref_rise = in_sync_ff[0] & ~ref_d_ff;
  wire ref_edge = ref_fall | (dbl_en & ref_rise);

  // Reference counter; code 0 divides by 32; held in load state in power-down
  logic [4:0] rcnt_ff;
  logic half_ff;
  logic pfd_ref_ff;
  wire r_wrap = ref_edge & (rcnt_ff == r_code - 5'h1);
  always_ff @(posedge clk) begin
    if (sys_rst || pwr_dn_ff) begin
      rcnt_ff <= 5'h0;
      half_ff <= 1'b0;
    end else if (ref_edge) begin
      rcnt_ff <= r_wrap ? 5'h0 : rcnt_ff + 5'h1;
      if (r_wrap) half_ff <= ~half_ff;
    end
  end

  // Detector reference: divider tick, or toggle output when halved
  wire pfd_tick = r_wrap & (~half_en | ~half_ff);
  always_ff @(posedge clk) begin
    if (sys_rst) pfd_ref_ff <= 1'b0;
    else pfd_ref_ff <= half_en ? half_ff : r_wrap;
  end

  // Ramp time step: one tick per step_div detector ticks
  logic [11:0] step_cnt_ff;
  logic step_tick_ff;
  wire step_wrap = pfd_tick & (step_cnt_ff + 12'h1 >= step_div);
  always_ff @(posedge clk) begin
    if (sys_rst || pwr_dn_ff) begin
      step_cnt_ff <= 12'h0;
      step_tick_ff <= 1'b0;
    end else begin
      if (pfd_tick) step_cnt_ff <= step_wrap ? 12'h0 : step_cnt_ff + 12'h1;
      step_tick_ff <= step_wrap;
    end
  end

  // Reference loss watchdog, restarted by every reference edge
  logic [15:0] idle_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || ref_rise || ref_fall) begin
      idle_ff <= 16'h0;
      ref_lost_ff <= 1'b0;
    end else if (idle_ff >= 16'(REF_LOSS_CYC - 1)) begin
      ref_lost_ff <= 1'b1;
    end else begin
      idle_ff <= idle_ff + 16'h1;
    end
  end

  // Lock detector on the OR of up and down
  wire pulse_end = pulse_d_ff & ~pfd_pulse;
  logic [3:0] width_ff;
  logic [4:0] pcnt_ff;
  logic [2:0] good_ff;
  wire [3:0] lock_thr = lock_precision_sel ? synth_cfg_pkg::LOCK_FINE_CYC :
                        synth_cfg_pkg::LOCK_COARSE_CYC;
  wire measured = pulse_end & (pcnt_ff == synth_cfg_pkg::MEASURE_LAST);
  wire short_p = width_ff <= lock_thr;
  wire long_p = width_ff > synth_cfg_pkg::UNLOCK_CYC;
  wire lose_ref = ~lock_loss_mode & ref_lost_ff;
  wire lock_clr = wr_fractional_value | pwr_dn_ff | lose_ref | (measured & long_p);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      width_ff <= 4'h0;
      pcnt_ff <= 5'h0;
    end else begin
      if (pfd_pulse) width_ff <= (width_ff == 4'hf) ? width_ff : width_ff + 4'h1;
      else width_ff <= 4'h0;
      if (pwr_dn_ff) pcnt_ff <= 5'h0;
      else if (pulse_end) pcnt_ff <= pcnt_ff + 5'h1;
    end
  end

  // Five consecutive short measured pulses set lock
  always_ff @(posedge clk) begin
    if (sys_rst || lock_clr) begin
      good_ff <= 3'h0;
      lock_ff <= 1'b0;
    end else if (measured) begin
      if (!short_p) good_ff <= 3'h0;
      else if (good_ff < 3'(synth_cfg_pkg::LOCK_COUNT)) good_ff <= good_ff + 3'h1;
      if (short_p && good_ff == 3'(synth_cfg_pkg::LOCK_COUNT - 1)) lock_ff <= 1'b1;
    end
  end

  // Frequency word write: modulator reset and integer/fraction load timing
  logic [2:0] pipe_ff;
  logic pipe_run_ff;
  logic mod_rst_ff;
  logic int_ld_ff;
  logic fractional_value_ld_ff;
  wire pipe_done = pipe_run_ff & (pipe_ff == 3'(synth_cfg_pkg::INT_PIPE_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pipe_ff <= 3'h0;
      pipe_run_ff <= 1'b0;
      mod_rst_ff <= 1'b0;
      int_ld_ff <= 1'b0;
      fractional_value_ld_ff <= 1'b0;
    end else begin
      if (wr_fractional_value) pipe_ff <= 3'h0;
      else if (pipe_run_ff) pipe_ff <= pipe_ff + 3'h1;
      pipe_run_ff <= wr_fractional_value | (pipe_run_ff & ~pipe_done);
      mod_rst_ff <= wr_fractional_value & ~modrst_off;
      int_ld_ff <= nsel ? pipe_done : wr_fractional_value;
      fractional_value_ld_ff <= pipe_done;
    end
  end

  // Gated pump controls and power-down state
  logic bleed_ff;
  logic tri_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwr_dn_ff <= 1'b0;
      bleed_ff <= 1'b0;
      tri_ff <= 1'b0;
    end else begin
      pwr_dn_ff <= pd_cfg;
      bleed_ff <= func_ff[synth_cfg_pkg::BLEED_EN_BIT] & ~pd_cfg;
      tri_ff <= pd_cfg;
    end
  end

  // Outputs; configuration fields other than bleed enable and power-down come straight from the word registers
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign pfd_ref_clk = pfd_ref_ff;
  assign ramp_step_tick = step_tick_ff;
  assign cycle_slip_reduce_en = refdiv_ff[synth_cfg_pkg::SLIP_BIT];
  assign cp_current_code = refdiv_ff[synth_cfg_pkg::CP_HI:synth_cfg_pkg::CP_LO];
  assign prescaler_89 = refdiv_ff[synth_cfg_pkg::PRESC_BIT];
  assign bleed_code = func_ff[synth_cfg_pkg::BLEED_HI:synth_cfg_pkg::BLEED_LO];
  assign bleed_en = bleed_ff;
  assign cp_tristate = tri_ff;
  assign ramp_mode = func_ff[synth_cfg_pkg::RAMP_HI:synth_cfg_pkg::RAMP_LO];
  assign psk_en = func_ff[synth_cfg_pkg::PSK_BIT];
  assign fsk_en = func_ff[synth_cfg_pkg::FSK_BIT];
  assign pd_polarity_pos = func_ff[synth_cfg_pkg::POL_BIT];
  assign power_down = pwr_dn_ff;
  assign lock_detect = lock_ff;
  assign mod_reset = mod_rst_ff;
  assign int_load = int_ld_ff;
  assign fractional_value_load = fractional_value_ld_ff;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_refdiv_only: assert property (wr_refdiv |=> refdiv_ff == $past(cword)
    && $stable(func_ff) && $stable(fractional_value_ff)) else $error("refdiv commit wrong");
  chk_func_only: assert property (wr_func |=> func_ff == $past(cword)
    && $stable(refdiv_ff)) else $error("function commit wrong");
  chk_bleed_gate: assert property (##1 bleed_en |->
    $past(func_ff[synth_cfg_pkg::BLEED_EN_BIT]) && !$past(pd_cfg))
    else $error("bleed on without enable");
  chk_lock_fractional_value_clear: assert property (wr_fractional_value |=> !lock_detect)
    else $error("lock survived frequency write");
  chk_pd_effects: assert property ($rose(pd_cfg) |=> ##1 cp_tristate && !lock_detect
    && rcnt_ff == 5'h0) else $error("power-down effects missing");
  chk_mod_reset: assert property (wr_fractional_value && !modrst_off |=> mod_reset)
    else $error("modulator reset missing");
  chk_int_delay: assert property (wr_fractional_value && nsel ##1 !wr_fractional_value[*4] |=> int_load && fractional_value_load)
    else $error("integer load not aligned");
  chk_lock_rise: assert property ($rose(lock_detect) |-> $past(measured) && $past(short_p))
    else $error("lock rose without measurement");
  chk_measure_32: assert property (pulse_end && pcnt_ff != synth_cfg_pkg::MEASURE_LAST
    |=> $stable(good_ff) || good_ff == 3'h0) else $error("unmeasured pulse counted");
endmodule

/* File: dv/serial_host.sv */
// Host controller that loads configuration words over the three-wire serial port
module serial_host (
  input wire logic clk,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock idles low outside frames
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b0;
  end

  // Shift one word MSB first, every level held for hold cycles, then latch it
  task automatic send(input logic [31:0] w, input int hold);
    for (int i = 31; i >= 0; i--) begin
      ser_data <= w[i];
      ser_clk <= 1'b0;
      repeat (hold) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (hold) @(posedge clk);
    end
    ser_clk <= 1'b0;
    ser_latch <= 1'b1;
    repeat (hold) @(posedge clk);
    ser_latch <= 1'b0;
    ser_data <= ~w[0]; // Released data line never shows the stale bit
    repeat (hold) @(posedge clk);
  endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the reference divider and function configuration block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst, reference_input, pfd_up, pfd_dn, hsel, hwrite, ref_run;
  logic [31:0] haddr, hwdata, hrdata, m_ref, m_func, m_fractional_value, d;
  logic [1:0] htrans, ramp_mode, rc;
  logic [2:0] hsize, bleed_code;
  logic [3:0] cp_current_code;
  logic hreadyout, hresp, pfd_ref_clk, ramp_step_tick, cycle_slip_reduce_en, prescaler_89;
  logic bleed_en, cp_tristate, psk_en, fsk_en, pd_polarity_pos, power_down, lock_detect;
  logic mod_reset, int_load, fractional_value_load, ser_clk, ser_data, ser_latch;
  int mismatches = 0, checked = 0, cyc = 0, t_mr, t_il, t_fl, np, nt;
  logic tab_h[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic tab_d[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  logic [4:0] tab_r[4] = '{5'h03, 5'h03, 5'h02, 5'h01};
  int tab_e[4] = '{8, 16, 6, 24};

  serial_host host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

  synth_ref_func_cfg #(.REF_LOSS_CYC(64)) dut (
    .clk(clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .reference_input(reference_input), .pfd_up(pfd_up),
    .pfd_dn(pfd_dn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pfd_ref_clk(pfd_ref_clk),
    .ramp_step_tick(ramp_step_tick), .cycle_slip_reduce_en(cycle_slip_reduce_en),
    .cp_current_code(cp_current_code), .prescaler_89(prescaler_89),
    .bleed_code(bleed_code), .bleed_en(bleed_en), .cp_tristate(cp_tristate),
    .ramp_mode(ramp_mode), .psk_en(psk_en), .fsk_en(fsk_en),
    .pd_polarity_pos(pd_polarity_pos), .power_down(power_down),
    .lock_detect(lock_detect), .mod_reset(mod_reset), .int_load(int_load),
    .fractional_value_load(fractional_value_load)
  );

  // 50 MHz clock
  always #10 clk = ~clk;

  // Reference toggles every four cycles while running; pulse moments recorded
  always @(posedge clk) begin
    rc <= rc + 2'h1;
    cyc <= cyc + 1;
    if (ref_run && rc == 2'h3) reference_input <= ~reference_input;
    if (mod_reset === 1'b1) t_mr <= cyc;
    if (int_load === 1'b1) t_il <= cyc;
    if (fractional_value_load === 1'b1) t_fl <= cyc;
  end

  task automatic end_sim();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hang anywhere in the run
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_near(input int got, input int exp);
    checked++;
    if (got < exp - 1 || got > exp + 1) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
  endtask

  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] w);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w;
    wait_rdy();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    r = hrdata;
  endtask

  // Reference model: control bits pick the register, other codes change nothing here
  task automatic put(input logic [31:0] w, input logic ser);
    case (w[2:0])
      3'h0: m_fractional_value = w;
      3'h2: m_ref = w;
      3'h3: m_func = w;
      default: ;
    endcase
    if (ser) host.send(w, 3 + 2 * w[3]);
    else ahb_wr(synth_cfg_pkg::ADDR_WORD, w);
    repeat (10) @(posedge clk);
  endtask

  // Unused bits zero; slip reduction only under positive polarity
  function automatic logic [31:0] mk_ref(input logic h, input logic dd, input logic [4:0] r,
                                         input logic [11:0] s);
    logic [31:0] w;
    w = $urandom;
    return {3'h0, w[28] & m_func[6], w[27:24], 1'b0, w[22], h, dd, r, s,
            synth_cfg_pkg::CTL_REFDIV};
  endfunction

  // Fixed one bit set, other unused bits zero, polarity kept positive under slip reduction
  function automatic logic [31:0] mk_func(input logic [1:0] m, input logic p, input logic l);
    logic [31:0] w;
    w = $urandom;
    return {7'h0, w[24:21], 3'h0, 1'b1, l, w[15:14], 2'h0, m, w[9:7], w[6] | m_ref[28], p,
            2'h0, synth_cfg_pkg::CTL_FUNC};
  endfunction

  // Integer field kept at 2048 or more, legal under either prescaler
  function automatic logic [31:0] mk_fractional_value();
    return {29'($urandom) | 29'h080_0000, synth_cfg_pkg::CTL_FRACTIONAL_VALUE};
  endfunction

  // Registers read back over the bus and decoded outputs against the model
  task automatic chk_all();
    rd(synth_cfg_pkg::ADDR_REFDIV, d);
    chk(d, m_ref);
    rd(synth_cfg_pkg::ADDR_FUNC, d);
    chk(d, m_func);
    rd(synth_cfg_pkg::ADDR_FRACTIONAL_VALUE, d);
    chk(d, m_fractional_value);
    chk({cycle_slip_reduce_en, cp_current_code, prescaler_89}, {m_ref[28:24], m_ref[22]});
    chk({bleed_code, bleed_en}, {m_func[24:22], m_func[21] & ~m_func[5]});
    chk({ramp_mode, psk_en, fsk_en, pd_polarity_pos}, {m_func[11:8], m_func[6]});
    chk({power_down, cp_tristate}, {2{m_func[5]}});
    chk({hresp, hreadyout}, 2'h1);
  endtask

  task automatic pulses(input int n, input int w);
    for (int i = 0; i < n; i++) begin
      if (i % 2) pfd_dn <= 1'b1;
      else pfd_up <= 1'b1;
      repeat (w) @(posedge clk);
      pfd_up <= 1'b0;
      pfd_dn <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  // Rising edges of the detector reference and ramp tick over 24 reference periods
  task automatic count();
    logic pp, pt;
    np = 0;
    nt = 0;
    pp = 1'b1;
    pt = 1'b1;
    repeat (256) @(posedge clk); // Counters left past the new end wrap first
    repeat (192) begin
      @(posedge clk);
      if (pfd_ref_clk === 1'b1 && pp === 1'b0) np++;
      if (ramp_step_tick === 1'b1 && pt === 1'b0) nt++;
      pp = pfd_ref_clk;
      pt = ramp_step_tick;
    end
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    {hsel, hwrite, pfd_up, pfd_dn, reference_input, ref_run, rc} = 8'h04;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    m_ref = synth_cfg_pkg::REFDIV_RST;
    m_func = synth_cfg_pkg::FUNC_RST;
    m_fractional_value = synth_cfg_pkg::FRACTIONAL_VALUE_RST;
    void'($urandom(15231));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk_all();
    rd(8'h14, d);
    chk(d, 32'h0);
    ahb_wr(synth_cfg_pkg::ADDR_REFDIV, ~m_ref);
    chk_all();
    for (int i = 0; i < 4; i++) begin
      put(mk_func(i[1:0], 1'b0, 1'b1), i[0]);
      put(mk_ref(1'b0, 1'b0, 5'($urandom), 12'($urandom)), ~i[0]);
      put({29'($urandom), 3'h5}, i[1]);
      chk_all();
    end
    for (int i = 0; i < 4; i++) begin
      put(mk_ref(tab_h[i], tab_d[i], tab_r[i], 12'h002), i[0]);
      count();
      chk_near(np, tab_e[i]);
      if (!tab_h[i]) chk_near(nt, tab_e[i] / 2);
    end
    for (int i = 0; i < 4; i++) begin
      d = mk_func(2'h0, 1'b0, 1'b1);
      d[15:14] = i[1:0];
      put(d, i[0]);
      {t_mr, t_il, t_fl} = {32'hffffffff, 32'hffffffff, 32'hffffffff};
      put(mk_fractional_value(), i[1]);
      chk(t_mr != -1, !i[0]);
      chk(t_fl != -1, 1'b1);
      chk(t_il + (i[1] ? 0 : 4), t_fl);
      chk_all();
    end
    pulses(100, 1);
    chk(lock_detect, 1'b0);
    pulses(100, 1);
    chk(lock_detect, 1'b1);
    put(mk_fractional_value(), 1'b1);
    chk(lock_detect, 1'b0);
    pulses(200, 1);
    pulses(40, 3);
    chk(lock_detect, 1'b0);
    pulses(200, 1);
    put(mk_func(2'h1, 1'b1, 1'b1), 1'b0);
    chk(lock_detect, 1'b0);
    put(mk_ref(1'b0, 1'b0, 5'h01, 12'h001), 1'b1);
    chk_all();
    rd(synth_cfg_pkg::ADDR_STATUS, d);
    chk(d[1:0], 2'h2);
    put(mk_func(2'h2, 1'b0, 1'b1), 1'b1);
    pulses(200, 1);
    ref_run <= 1'b0;
    repeat (150) @(posedge clk);
    chk(lock_detect, 1'b1);
    put(mk_func(2'h3, 1'b0, 1'b0), 1'b0);
    repeat (150) @(posedge clk);
    chk(lock_detect, 1'b0);
    rd(synth_cfg_pkg::ADDR_STATUS, d);
    chk(d[2:0], 3'h4);
    ref_run <= 1'b1;
    chk_all();
    end_sim();
  end
endmodule
